// file: hdl/lefc_axi_slave.v
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: Data 32 bits, register index from address bits 7:2
// Notes: Access pulses are combinational, responses are registered
`timescale 1ns/1ps
`include "lefc_defs.vh"
module lefc_axi_slave (
    // Clock and reset
    input wire ref_clk,
    input wire sys_rst,
    // Write address and data
    input wire [`LEFC_AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [`LEFC_DW-1:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // Write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // Read address and data
    input wire [`LEFC_AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [`LEFC_DW-1:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Register side
    output wire wr_en,
    output wire [`LEFC_IW-1:0] wr_idx,
    output wire [7:0] wr_byte,
    output wire wr_lane0,
    input wire wr_err,
    output wire rd_en,
    output wire [`LEFC_IW-1:0] rd_idx,
    input wire [7:0] rd_byte,
    input wire rd_err
);

    reg aw_full_q;
    reg w_full_q;
    reg ar_full_q;
    reg [`LEFC_AW-1:0] awaddr_q;
    reg [`LEFC_AW-1:0] araddr_q;
    reg [7:0] wbyte_q;
    reg lane0_q;
    reg aw_full_d;
    reg w_full_d;
    reg ar_full_d;
    reg bvalid_d;
    reg rvalid_d;

    assign wr_en = aw_full_q & w_full_q & ~s_axi_bvalid;
    assign wr_idx = awaddr_q[7:2];
    assign wr_byte = wbyte_q;
    assign wr_lane0 = lane0_q;
    assign rd_en = ar_full_q & ~s_axi_rvalid;
    assign rd_idx = araddr_q[7:2];

    always @* begin
        aw_full_d = aw_full_q;
        w_full_d = w_full_q;
        ar_full_d = ar_full_q;
        bvalid_d = s_axi_bvalid;
        rvalid_d = s_axi_rvalid;
        if (s_axi_awvalid & s_axi_awready) begin
            aw_full_d = 1'b1;
        end
        if (s_axi_wvalid & s_axi_wready) begin
            w_full_d = 1'b1;
        end
        if (wr_en) begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
        end else if (s_axi_bvalid & s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (s_axi_arvalid & s_axi_arready) begin
            ar_full_d = 1'b1;
        end
        if (rd_en) begin
            ar_full_d = 1'b0;
            rvalid_d = 1'b1;
        end else if (s_axi_rvalid & s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            ar_full_q <= 1'b0;
            awaddr_q <= 8'h00;
            araddr_q <= 8'h00;
            wbyte_q <= 8'h00;
            lane0_q <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_arready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LEFC_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `LEFC_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            ar_full_q <= ar_full_d;
            s_axi_bvalid <= bvalid_d;
            s_axi_rvalid <= rvalid_d;
            // Ready drops while a slot is held or an answer waits
            s_axi_awready <= ~aw_full_d & ~bvalid_d;
            s_axi_wready <= ~w_full_d & ~bvalid_d;
            s_axi_arready <= ~ar_full_d & ~rvalid_d;
            if (s_axi_awvalid & s_axi_awready) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                wbyte_q <= s_axi_wdata[7:0];
                lane0_q <= s_axi_wstrb[0];
            end
            if (s_axi_arvalid & s_axi_arready) begin
                araddr_q <= s_axi_araddr;
            end
            if (wr_en) begin
                s_axi_bresp <= wr_err ? `LEFC_RESP_SLVERR : `LEFC_RESP_OKAY;
            end
            if (rd_en) begin
                s_axi_rdata <= {24'h00_0000, rd_byte};
                s_axi_rresp <= rd_err ? `LEFC_RESP_SLVERR : `LEFC_RESP_OKAY;
            end
        end
    end

endmodule // lefc_axi_slave

// file: hdl/lefc_coeff_pair.v
// Purpose: One 16-bit coefficient held as high and low bytes
// Assumes: High byte written first, low byte next
// Notes: The active value changes only on a low byte write
`timescale 1ns/1ps
module lefc_coeff_pair #(
    parameter [7:0] RST_HI = 8'h00,
    parameter [7:0] RST_LO = 8'h00
) (
    // Clock and reset
    input wire ref_clk,
    input wire sys_rst,
    // Byte writes
    input wire wr_hi,
    input wire wr_lo,
    input wire [7:0] wdata,
    // Stored bytes and state
    output reg [7:0] hi_q,
    output reg [7:0] lo_q,
    output reg signed [15:0] active_q,
    output reg pending_q
);

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            hi_q <= RST_HI;
            lo_q <= RST_LO;
            active_q <= {RST_HI, RST_LO};
            pending_q <= 1'b0;
        end else begin
            if (wr_hi) begin
                hi_q <= wdata;
                pending_q <= 1'b1; // R11
            end
            if (wr_lo) begin
                lo_q <= wdata;
                // Halves go live together, never mixed
                active_q <= {hi_q, wdata}; // R11
                pending_q <= wr_hi;
            end
        end
    end

endmodule // lefc_coeff_pair

// file: hdl/lefc_coeff_regs.v
// Purpose: Left effects filter coefficient bank behind AXI4-Lite
// Assumes: Single clock ref_clk at 10 MHz, synchronous reset
// Notes: Coefficient bytes are mapped only while the page bit is one
//   Index 0 holds the page bit and is mapped on both pages
//   Index 32 flags pairs whose high byte awaits its low byte
//   Refused accesses answer SLVERR and change nothing
//   A write with strobe lane 0 clear stores nothing
//   A high byte reads back at once, before it goes live
//   Live pair values move on the edge that stores the low byte
//
// Notes on behaviour
// [R01] Each coefficient is a signed 16-bit value from high and low bytes.
// [R02] Coefficient bytes sit at indices 6 to 15 in the listed order.
// [R03] Third numerator low byte resets to 5d, read and write.
// [R04] Fourth numerator resets to 6b and e3, read and write.
// [R05] Fifth numerator resets to 96 and 66, read and write.
// [R06] Sixth numerator resets to 67 and 5d, read and write.
// [R07] First denominator resets to 7d and 83, read and write.
// [R08] Second denominator high byte resets to 84, read and write.
// [R09] Software writes high byte then low byte, always both.
// [R10] Coefficient bytes reachable only with page bit one; zero selects page 0.
// [R11] High byte waits for its low byte; halves never mix.
`timescale 1ns/1ps
`include "lefc_defs.vh"
module lefc_coeff_regs (
    // Clock and reset
    input wire ref_clk,
    input wire sys_rst,
    // AXI4-Lite write address
    input wire [`LEFC_AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [`LEFC_DW-1:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [`LEFC_AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output wire [`LEFC_DW-1:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // Page state
    output reg page_sel_q,
    // Coefficients seen by the filter
    output reg [7:0] numerator_term_two_low_q,
    output wire signed [15:0] numerator_term_three_q,
    output wire signed [15:0] numerator_term_four_q,
    output wire signed [15:0] numerator_term_five_q,
    output wire signed [15:0] denominator_term_one_q,
    output reg [7:0] denominator_term_two_high_q
);

    // Register side of the bus front end
    wire wr_en;
    wire [`LEFC_IW-1:0] wr_idx;
    wire [7:0] wr_byte;
    wire wr_lane0;
    wire rd_en;
    wire [`LEFC_IW-1:0] rd_idx;
    reg wr_err;
    reg rd_err;
    reg [7:0] rd_byte;

    // Stored bytes of each pair
    wire [7:0] num3_hi;
    wire [7:0] num3_lo;
    wire [7:0] num4_hi;
    wire [7:0] num4_lo;
    wire [7:0] num5_hi;
    wire [7:0] num5_lo;
    wire [7:0] den1_hi;
    wire [7:0] den1_lo;
    wire [3:0] pending;
    wire [7:0] status_byte;

    // Byte write strobes
    wire wr_ok;
    wire wr_num3_hi;
    wire wr_num3_lo;
    wire wr_num4_hi;
    wire wr_num4_lo;
    wire wr_num5_hi;
    wire wr_num5_lo;
    wire wr_den1_hi;
    wire wr_den1_lo;
    wire wr_page;
    wire wr_num2_lo;
    wire wr_den2_hi;

    // Index lies in the paged coefficient window
    function is_coeff;
        input [`LEFC_IW-1:0] idx;
        begin
            is_coeff = (idx >= `LEFC_IDX_NUM2_LO) &&
                (idx <= `LEFC_IDX_DEN2_HI); // R02
        end
    endfunction

    // Index is mapped for the current page
    function is_mapped;
        input [`LEFC_IW-1:0] idx;
        input page;
        begin
            is_mapped = (idx == `LEFC_IDX_PAGE) ||
                (idx == `LEFC_IDX_STATUS) ||
                (is_coeff(idx) && page); // R10
        end
    endfunction

    // Strobe for one register byte
    function hit;
        input [`LEFC_IW-1:0] idx;
        input [`LEFC_IW-1:0] want;
        begin
            hit = (idx == want);
        end
    endfunction

    lefc_axi_slave u_bus (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .wr_byte(wr_byte),
        .wr_lane0(wr_lane0),
        .wr_err(wr_err),
        .rd_en(rd_en),
        .rd_idx(rd_idx),
        .rd_byte(rd_byte),
        .rd_err(rd_err)
    );

    // Lane 0 off means a mapped write stores nothing
    assign wr_ok = wr_en & wr_lane0 & ~wr_err;
    assign wr_num3_hi = wr_ok & hit(wr_idx, `LEFC_IDX_NUM3_HI);
    assign wr_num3_lo = wr_ok & hit(wr_idx, `LEFC_IDX_NUM3_LO);
    assign wr_num4_hi = wr_ok & hit(wr_idx, `LEFC_IDX_NUM4_HI);
    assign wr_num4_lo = wr_ok & hit(wr_idx, `LEFC_IDX_NUM4_LO);
    assign wr_num5_hi = wr_ok & hit(wr_idx, `LEFC_IDX_NUM5_HI);
    assign wr_num5_lo = wr_ok & hit(wr_idx, `LEFC_IDX_NUM5_LO);
    assign wr_den1_hi = wr_ok & hit(wr_idx, `LEFC_IDX_DEN1_HI);
    assign wr_den1_lo = wr_ok & hit(wr_idx, `LEFC_IDX_DEN1_LO);
    assign wr_page = wr_ok & hit(wr_idx, `LEFC_IDX_PAGE);
    assign wr_num2_lo = wr_ok & hit(wr_idx, `LEFC_IDX_NUM2_LO);
    assign wr_den2_hi = wr_ok & hit(wr_idx, `LEFC_IDX_DEN2_HI);

    // Pending flags of the four pairs, upper bits read zero
    assign status_byte = {4'h0, pending}; // R11

    // Page gate, write side
    always @* begin
        wr_err = 1'b0;
        if (!is_mapped(wr_idx, page_sel_q)) begin
            wr_err = 1'b1; // R10
        end
    end

    // Page gate, read side; a refused read returns zero
    always @* begin
        rd_err = 1'b0;
        if (!is_mapped(rd_idx, page_sel_q)) begin
            rd_err = 1'b1; // R10
        end
    end

    // Full pairs; software must send high then low to update
    lefc_coeff_pair #(
        .RST_HI(`LEFC_RST_NUM3_HI),
        .RST_LO(`LEFC_RST_NUM3_LO)
    ) u_num3 (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .wr_hi(wr_num3_hi), // R04
        .wr_lo(wr_num3_lo), // R09
        .wdata(wr_byte),
        .hi_q(num3_hi),
        .lo_q(num3_lo),
        .active_q(numerator_term_three_q), // R01
        .pending_q(pending[`LEFC_PEND_NUM3])
    );

    lefc_coeff_pair #(
        .RST_HI(`LEFC_RST_NUM4_HI),
        .RST_LO(`LEFC_RST_NUM4_LO)
    ) u_num4 (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .wr_hi(wr_num4_hi), // R05
        .wr_lo(wr_num4_lo),
        .wdata(wr_byte),
        .hi_q(num4_hi),
        .lo_q(num4_lo),
        .active_q(numerator_term_four_q),
        .pending_q(pending[`LEFC_PEND_NUM4])
    );

    lefc_coeff_pair #(
        .RST_HI(`LEFC_RST_NUM5_HI),
        .RST_LO(`LEFC_RST_NUM5_LO)
    ) u_num5 (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .wr_hi(wr_num5_hi), // R06
        .wr_lo(wr_num5_lo),
        .wdata(wr_byte),
        .hi_q(num5_hi),
        .lo_q(num5_lo),
        .active_q(numerator_term_five_q),
        .pending_q(pending[`LEFC_PEND_NUM5])
    );

    lefc_coeff_pair #(
        .RST_HI(`LEFC_RST_DEN1_HI),
        .RST_LO(`LEFC_RST_DEN1_LO)
    ) u_den1 (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .wr_hi(wr_den1_hi), // R07
        .wr_lo(wr_den1_lo),
        .wdata(wr_byte),
        .hi_q(den1_hi),
        .lo_q(den1_lo),
        .active_q(denominator_term_one_q),
        .pending_q(pending[`LEFC_PEND_DEN1])
    );

    // Page bit, reachable on either page
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            page_sel_q <= `LEFC_RST_PAGE;
        end else if (wr_page) begin
            page_sel_q <= wr_byte[`LEFC_PAGE_BIT]; // R10
        end
    end

    // Lone bytes; their partners live outside this bank
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            numerator_term_two_low_q <= `LEFC_RST_NUM2_LO; // R03
        end else if (wr_num2_lo) begin
            numerator_term_two_low_q <= wr_byte; // R03
        end
    end

    // No hold here, so the byte goes live at once
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            denominator_term_two_high_q <= `LEFC_RST_DEN2_HI; // R08
        end else if (wr_den2_hi) begin
            denominator_term_two_high_q <= wr_byte; // R08
        end
    end

    // Read mux; unmapped or wrong page reads zero
    always @* begin
        rd_byte = 8'h00;
        if (!rd_err) begin
            case (rd_idx)
                `LEFC_IDX_PAGE: rd_byte = {7'h00, page_sel_q};
                `LEFC_IDX_STATUS: rd_byte = status_byte;
                `LEFC_IDX_NUM2_LO: rd_byte = numerator_term_two_low_q;
                `LEFC_IDX_NUM3_HI: rd_byte = num3_hi;
                `LEFC_IDX_NUM3_LO: rd_byte = num3_lo;
                `LEFC_IDX_NUM4_HI: rd_byte = num4_hi;
                `LEFC_IDX_NUM4_LO: rd_byte = num4_lo;
                `LEFC_IDX_NUM5_HI: rd_byte = num5_hi;
                `LEFC_IDX_NUM5_LO: rd_byte = num5_lo;
                `LEFC_IDX_DEN1_HI: rd_byte = den1_hi;
                `LEFC_IDX_DEN1_LO: rd_byte = den1_lo;
                `LEFC_IDX_DEN2_HI: rd_byte = denominator_term_two_high_q;
                default: rd_byte = 8'h00;
            endcase
        end
    end

endmodule // lefc_coeff_regs

// file: hdl/lefc_defs.vh
// Purpose: Constants for the left effects filter coefficient bank
// Assumes: Register index times four gives the AXI4-Lite byte address
// Notes: Definitions only
`ifndef LEFC_DEFS_VH
`define LEFC_DEFS_VH

// Bus widths
`define LEFC_AW 8
`define LEFC_DW 32
`define LEFC_IW 6

// Register indices
`define LEFC_IDX_PAGE 6'h00
`define LEFC_IDX_NUM2_LO 6'h06
`define LEFC_IDX_NUM3_HI 6'h07
`define LEFC_IDX_NUM3_LO 6'h08
`define LEFC_IDX_NUM4_HI 6'h09
`define LEFC_IDX_NUM4_LO 6'h0a
`define LEFC_IDX_NUM5_HI 6'h0b
`define LEFC_IDX_NUM5_LO 6'h0c
`define LEFC_IDX_DEN1_HI 6'h0d
`define LEFC_IDX_DEN1_LO 6'h0e
`define LEFC_IDX_DEN2_HI 6'h0f
`define LEFC_IDX_STATUS 6'h20

// Field positions
`define LEFC_PAGE_BIT 0
`define LEFC_PEND_NUM3 0
`define LEFC_PEND_NUM4 1
`define LEFC_PEND_NUM5 2
`define LEFC_PEND_DEN1 3

// Reset values
`define LEFC_RST_NUM2_LO 8'h5d
`define LEFC_RST_NUM3_HI 8'h6b
`define LEFC_RST_NUM3_LO 8'he3
`define LEFC_RST_NUM4_HI 8'h96
`define LEFC_RST_NUM4_LO 8'h66
`define LEFC_RST_NUM5_HI 8'h67
`define LEFC_RST_NUM5_LO 8'h5d
`define LEFC_RST_DEN1_HI 8'h7d
`define LEFC_RST_DEN1_LO 8'h83
`define LEFC_RST_DEN2_HI 8'h84
`define LEFC_RST_PAGE 1'b0

// Responses
`define LEFC_RESP_OKAY 2'b00
`define LEFC_RESP_SLVERR 2'b10

`endif

// file: testbench/lefc_coeff_regs_asserts.sv
// Purpose: Port checks for the coefficient bank
// Assumes: Two-cycle bus answers, one transfer at a time
// Notes: Bound into every bank instance
`timescale 1ns/1ps
`include "lefc_defs.vh"
module lefc_regs_chk (
    // Clock and reset
    input logic ref_clk,
    input logic sys_rst,
    // Bus
    input logic [`LEFC_AW-1:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic [`LEFC_DW-1:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [`LEFC_AW-1:0] s_axi_araddr,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [`LEFC_DW-1:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    // Page and coefficients
    input logic page_sel_q,
    input logic [7:0] numerator_term_two_low_q,
    input logic signed [15:0] numerator_term_three_q,
    input logic signed [15:0] numerator_term_four_q,
    input logic signed [15:0] numerator_term_five_q,
    input logic signed [15:0] denominator_term_one_q,
    input logic [7:0] denominator_term_two_high_q
);
    wire aw_go = s_axi_awvalid && s_axi_awready;
    wire wr_go = aw_go && s_axi_wvalid && s_axi_wready;
    wire rd_go = s_axi_arvalid && s_axi_arready;
    wire [5:0] w_idx = s_axi_awaddr[7:2];
    wire [5:0] r_idx = s_axi_araddr[7:2];
    // Coefficient stores only happen on page one with lane 0 enabled
    wire wr_st = wr_go && page_sel_q && s_axi_wstrb[0];
    wire w_coef = w_idx >= 6'h06 && w_idx <= 6'h0f;
    wire r_coef = r_idx >= 6'h06 && r_idx <= 6'h0f;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_rst_num;
        $fell(sys_rst) |-> numerator_term_two_low_q == 8'h5d &&
            numerator_term_three_q == 16'h6be3 &&
            numerator_term_four_q == 16'h9666;
    endproperty
    a_rst_num: assert property (p_rst_num)
        else $error("numerator reset value wrong");
    property p_rst_den;
        $fell(sys_rst) |-> numerator_term_five_q == 16'h675d &&
            denominator_term_one_q == 16'h7d83 &&
            denominator_term_two_high_q == 8'h84 && !page_sel_q;
    endproperty
    a_rst_den: assert property (p_rst_den)
        else $error("denominator reset value wrong");
    property p_wr_lat;
        wr_go |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    a_wr_lat: assert property (p_wr_lat)
        else $error("write response timing wrong");
    property p_wr_page;
        wr_go && w_coef && !page_sel_q |-> ##2
            s_axi_bvalid && s_axi_bresp == 2'b10;
    endproperty
    a_wr_page: assert property (p_wr_page)
        else $error("page zero write not refused");
    property p_rd_lat;
        rd_go |=> !s_axi_rvalid ##1
            (s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000);
    endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("read answer timing or width wrong");
    property p_rd_page;
        rd_go && r_coef && !page_sel_q |-> ##2 s_axi_rresp == 2'b10 &&
            s_axi_rdata == 32'h0000_0000;
    endproperty
    a_rd_page: assert property (p_rd_page)
        else $error("page zero read not refused");
    property p_hi_hold;
        wr_st && w_idx == 6'h07 |=> $stable(numerator_term_three_q)[*3];
    endproperty
    a_hi_hold: assert property (p_hi_hold)
        else $error("high byte applied without low byte");
    property p_lo_apply;
        wr_st && w_idx == 6'h08 |-> ##3
            numerator_term_three_q[7:0] == $past(s_axi_wdata[7:0], 3);
    endproperty
    a_lo_apply: assert property (p_lo_apply)
        else $error("low byte not applied");
    property p_lone;
        wr_st && w_idx == 6'h06 |-> ##2
            numerator_term_two_low_q == $past(s_axi_wdata[7:0], 2);
    endproperty
    a_lone: assert property (p_lone)
        else $error("lone low byte not stored");
endmodule // lefc_regs_chk

bind lefc_coeff_regs lefc_regs_chk chk_u (.*);

// file: testbench/tb.sv
// Purpose: Self-checking bench for the coefficient bank
// Assumes: Master waits on every handshake, no fixed latency
// Notes: A monitor compares answers against queued expectations
`timescale 1ns/1ps
`include "lefc_defs.vh"
module tb;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, page_sel_q;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0] numerator_term_two_low_q, denominator_term_two_high_q;
    logic signed [15:0] numerator_term_three_q, numerator_term_four_q;
    logic signed [15:0] numerator_term_five_q, denominator_term_one_q;
    logic [1:0] exp_b[$];
    logic [33:0] exp_r[$];
    logic [7:0] rst_val [10] = '{8'h5d, 8'h6b, 8'he3, 8'h96, 8'h66,
        8'h67, 8'h5d, 8'h7d, 8'h83, 8'h84};
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    localparam logic [1:0] OK = 2'b00;
    localparam logic [1:0] ERR = 2'b10;

    lefc_coeff_regs dut_u (.*);

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic chk(input string nm, input logic [33:0] e,
                       input logic [33:0] g);
        num_checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Low address bits and upper data bits are noise the bank ignores
    task automatic wr(input logic [5:0] idx, input logic [7:0] d,
                      input logic [3:0] s, input logic [1:0] rsp);
        logic aw_ok, w_ok;
        @(posedge ref_clk);
        aw_ok = 1'b0;
        w_ok = 1'b0;
        exp_b.push_back(rsp);
        s_axi_awaddr <= {idx, 2'($urandom())};
        s_axi_wdata <= {24'($urandom()), d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge ref_clk);
            if (!aw_ok && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (!s_axi_bvalid) @(posedge ref_clk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] idx, input logic [1:0] rsp,
                      input logic [7:0] d);
        @(posedge ref_clk);
        exp_r.push_back({rsp, 24'h00_0000, d});
        s_axi_araddr <= {idx, 2'($urandom())};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge ref_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge ref_clk);
        s_axi_rready <= 1'b0;
    endtask

    function automatic logic [15:0] live(input int p);
        case (p)
            0: return numerator_term_three_q;
            1: return numerator_term_four_q;
            2: return numerator_term_five_q;
            default: return denominator_term_one_q;
        endcase
    endfunction

    task automatic rst_check();
        chk("n34", 32'h6be3_9666, {numerator_term_three_q,
            numerator_term_four_q});
        chk("n5d1", 32'h675d_7d83, {numerator_term_five_q,
            denominator_term_one_q});
        chk("lone", 16'h5d84, {numerator_term_two_low_q,
            denominator_term_two_high_q});
        rd(6'h00, OK, 8'h00);
        rd(6'h07, ERR, 8'h00);
        wr(6'h00, 8'h01, 4'h1, OK);
        for (int i = 0; i < 10; i++)
            rd(6'(6 + i), OK, rst_val[i]);
    endtask

    always @(posedge ref_clk) begin
        if (s_axi_bvalid && s_axi_bready)
            chk("bresp", exp_b.pop_front(), s_axi_bresp);
        if (s_axi_rvalid && s_axi_rready)
            chk("rdata", exp_r.pop_front(), {s_axi_rresp, s_axi_rdata});
    end

    // Whole run needs a few hundred cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end

    initial begin
        logic [7:0] hi, lo, v;
        logic [15:0] was;
        void'($urandom(32'hb291));
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        rst_check();
        $display("test reset values done");
        for (int p = 0; p < 4; p++) begin
            hi = (p == 0) ? 8'h80 : (p == 3) ? 8'h7f : 8'($urandom());
            lo = (p == 0) ? 8'h00 : (p == 3) ? 8'hff : 8'($urandom());
            was = live(p);
            wr(6'(7 + 2 * p), hi, 4'hf, OK);
            @(negedge ref_clk);
            chk("held", was, live(p));
            rd(6'(7 + 2 * p), OK, hi);
            rd(6'h20, OK, 8'(1 << p));
            wr(6'(8 + 2 * p), lo, 4'h1, OK);
            @(negedge ref_clk);
            chk("live", {hi, lo}, live(p));
            if (p == 0)
                chk("neg", 1'b1, numerator_term_three_q < 0);
            rd(6'(8 + 2 * p), OK, lo);
            rd(6'h20, OK, 8'h00);
        end
        $display("test coefficient pairs done");
        for (int k = 0; k < 2; k++) begin
            v = 8'($urandom());
            wr(k ? 6'h0f : 6'h06, v, 4'h1, OK);
            @(negedge ref_clk);
            chk("byte", v, k ? denominator_term_two_high_q
                : numerator_term_two_low_q);
            rd(k ? 6'h0f : 6'h06, OK, v);
        end
        wr(6'h0f, ~v, 4'h0, OK);
        rd(6'h0f, OK, v);
        $display("test lone bytes done");
        wr(6'h00, 8'h00, 4'h1, OK);
        wr(6'h07, 8'h11, 4'h1, ERR);
        rd(6'h07, ERR, 8'h00);
        wr(6'h00, 8'hff, 4'h1, OK);
        rd(6'h00, OK, 8'h01);
        rd(6'h07, OK, 8'h80);
        wr(6'h10, 8'h55, 4'h1, ERR);
        rd(6'h10, ERR, 8'h00);
        $display("test page and unmapped done");
        sys_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        rst_check();
        $display("test second reset done");
        conclude();
    end
endmodule // tb
